// File: lcfh_pkg.sv
// Constants and types for the local command frame handler.
// Assumes byte-wide receive and transmit streams on one 40 MHz clock.
package lcfh_pkg;
	localparam logic [7:0] DELIM = 8'h7e;
	localparam logic [7:0] CSUM_TARGET = 8'hff;
	localparam logic [7:0] TYPE_IMM = 8'h08;
	localparam logic [7:0] TYPE_QUE = 8'h09;
	localparam logic [7:0] TYPE_RESP = 8'h88;
	localparam logic [7:0] TYPE_STAT = 8'h8a;
	localparam logic [15:0] MIN_LEN = 16'h0004;
	localparam logic [15:0] CMD_APPLY = 16'h4143;
	localparam logic [15:0] CMD_TEMP = 16'h5450;
	localparam int NSLOT = 2;
	localparam logic [NSLOT-1:0][15:0] SLOT_CMD = {16'h4150, 16'h4244};
	localparam logic [NSLOT-1:0][7:0] SLOT_RST = {8'h01, 8'h03};
	localparam logic [7:0] ST_OK = 8'h00;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_PARAM = 8'h03;
	localparam int NSTAT = 6;
	localparam logic [NSTAT-1:0][7:0] STAT_CODE = {8'h0d, 8'h06, 8'h03, 8'h02, 8'h01, 8'h00};
	localparam logic [7:0] RESP_LEN_BASE = 8'h05;
	localparam logic [7:0] STAT_LEN = 8'h02;
	localparam logic [3:0] IDX_LENH = 4'h1;
	localparam logic [3:0] IDX_LEN = 4'h2;
	localparam logic [3:0] IDX_TYPE = 4'h3;
	localparam logic [3:0] IDX_FID = 4'h4;
	localparam logic [3:0] IDX_CMDH = 4'h5;
	localparam logic [3:0] IDX_CMDL = 4'h6;
	localparam logic [3:0] IDX_ST = 4'h7;
	localparam logic [3:0] IDX_D0 = 4'h8;
	localparam int FIFO_DEPTH = 32;
	localparam int BYTE_W = 8;

	typedef enum logic [2:0] {R_DELIM, R_LENH, R_LENL, R_BODY, R_CSUM, R_EXEC} lcfh_rx_e_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} lcfh_byte_t;

	typedef struct packed {
		lcfh_rx_e_t rs;
		logic [15:0] len;
		logic [15:0] cnt;
		logic [7:0] sum;
		logic [7:0] ftype;
		logic [7:0] fid;
		logic [15:0] cmd;
		logic [7:0] val;
		logic has_val;
		logic [NSLOT-1:0][7:0] act;
		logic [NSLOT-1:0][7:0] pend;
		logic [NSLOT-1:0] pv;
		logic [NSTAT-1:0] stat_pend;
		logic rx_rdy;
		logic tx_busy;
		logic [3:0] tx_idx;
		logic [3:0] tx_last;
		logic [7:0] tx_sum;
		logic [7:0] r_type;
		logic [7:0] r_fid;
		logic [15:0] r_cmd;
		logic [7:0] r_st;
		logic [15:0] r_data;
		logic [1:0] r_dlen;
	} lcfh_state_t;
endpackage

// File: lcfh_fifo.sv
// Byte FIFO between the frame builder and the transmit stream.
// Assumes the drain side may stall for any time; read data leave a register.
`timescale 1ns/10ps
`default_nettype none
module lcfh_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ov;
		logic [W-1:0] od;
	} lcfh_fifo_st_t;

	lcfh_fifo_st_t q, next_q;
	logic wr, rd;

	////////////////////////////////////////////////////////////////
	always_comb begin
		next_q = q;
		in_ready = (q.cnt != (AW+1)'(DEPTH));
		wr = in_valid && in_ready;
		// Refill the output register whenever it is empty or being taken
		rd = (q.cnt != '0) && (!q.ov || out_ready);
		if (out_ready) begin
			next_q.ov = 1'b0;
		end
		if (rd) begin
			next_q.ov = 1'b1;
			next_q.od = q.mem[q.rp];
			next_q.rp = q.rp + 1'b1;
		end
		if (wr) begin
			next_q.mem[q.wp] = in_data;
			next_q.wp = q.wp + 1'b1;
		end
		next_q.cnt = q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign out_valid = q.ov;
	assign out_data = q.od;
endmodule
`default_nettype wire

// File: lcfh_top.sv
// Local command frame handler: parses request frames, keeps parameters, builds answers.
// Assumes rx and tx are byte streams with valid/ready on clk; escaped framing is absent.
`timescale 1ns/10ps
`default_nettype none
module lcfh_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic [15:0] temp_value,
	input wire logic [lcfh_pkg::NSTAT-1:1] status_event,
	output logic [7:0] serial_baud_setting,
	output logic [7:0] api_escape_mode_setting,
	output logic [lcfh_pkg::NSLOT-1:0] pending_flags
);
	import lcfh_pkg::*;

	lcfh_state_t q, next_q;
	logic acc, push, push_ok, csum_good, frame_ok, exec_go;
	logic [7:0] b, tx_byte, next_sum;
	logic [NSTAT-1:0] stat_clr;
	logic seen_type;
	logic [7:0] req_fid;

	////////////////////////////////////////////////////////////////
	// Receive parser, command execution and frame builder
	always_comb begin
		next_q = q;
		b = rx_data;
		acc = rx_valid && q.rx_rdy;
		next_sum = q.sum + b;
		csum_good = (next_sum == CSUM_TARGET);
		frame_ok = csum_good && (q.len >= MIN_LEN) &&
			(q.ftype == TYPE_IMM || q.ftype == TYPE_QUE);
		exec_go = (q.rs == R_EXEC) && !q.tx_busy;
		stat_clr = '0;
		if (acc) begin
			unique case (q.rs)
				R_DELIM: begin
					if (b == DELIM) begin
						next_q.rs = R_LENH;
					end
				end
				R_LENH: begin
					next_q.len[15:8] = b;
					next_q.rs = R_LENL;
				end
				R_LENL: begin
					next_q.len[7:0] = b;
					next_q.cnt = '0;
					next_q.sum = '0;
					next_q.has_val = 1'b0;
					next_q.ftype = '0;
					next_q.rs = ({q.len[15:8], b} == '0) ? R_CSUM : R_BODY;
				end
				R_BODY: begin
					next_q.sum = next_sum;
					next_q.cnt = q.cnt + 1'b1;
					unique case (q.cnt)
						16'h0000: next_q.ftype = b;
						16'h0001: next_q.fid = b;
						16'h0002: next_q.cmd[15:8] = b;
						16'h0003: next_q.cmd[7:0] = b;
						default: begin
							// Parameters are one byte wide; the last value byte wins
							next_q.val = b;
							next_q.has_val = 1'b1;
						end
					endcase
					if (q.cnt + 1'b1 == q.len) begin
						next_q.rs = R_CSUM;
					end
				end
				R_CSUM: begin
					next_q.rs = frame_ok ? R_EXEC : R_DELIM;
				end
				default: begin
				end
			endcase
		end
		if (exec_go) begin
			next_q.rs = R_DELIM;
			next_q.r_type = TYPE_RESP;
			next_q.r_fid = q.fid;
			next_q.r_cmd = q.cmd;
			next_q.r_st = ST_OK;
			next_q.r_data = '0;
			next_q.r_dlen = 2'd0;
			// Any immediate frame releases queued values before its own set
			if (q.ftype == TYPE_IMM) begin
				for (int i = 0; i < NSLOT; i++) begin
					if (q.pv[i]) begin
						next_q.act[i] = q.pend[i];
					end
				end
				next_q.pv = '0;
			end
			if (q.cmd == CMD_APPLY) begin
				for (int i = 0; i < NSLOT; i++) begin
					if (q.pv[i]) begin
						next_q.act[i] = q.pend[i];
					end
				end
				next_q.pv = '0;
			end else if (q.cmd == CMD_TEMP) begin
				if (q.has_val) begin
					next_q.r_st = ST_BAD_PARAM;
				end else begin
					next_q.r_data = temp_value;
					next_q.r_dlen = 2'd2;
				end
			end else begin
				next_q.r_st = ST_BAD_CMD;
				for (int i = 0; i < NSLOT; i++) begin
					if (q.cmd == SLOT_CMD[i]) begin
						next_q.r_st = ST_OK;
						if (!q.has_val) begin
							// Queries return the active value on both types
							next_q.r_data = {8'h00, q.act[i]};
							next_q.r_dlen = 2'd1;
						end else if (q.ftype == TYPE_IMM) begin
							next_q.act[i] = q.val;
						end else begin
							next_q.pend[i] = q.val;
							next_q.pv[i] = 1'b1;
						end
					end
				end
			end
			if (q.fid != '0) begin
				next_q.tx_busy = 1'b1;
				next_q.tx_idx = '0;
				next_q.tx_sum = '0;
				next_q.tx_last = IDX_TYPE + 4'(RESP_LEN_BASE) + {2'b00, next_q.r_dlen};
			end
		end else if (!q.tx_busy && q.rs != R_EXEC && q.stat_pend != '0) begin
			// Status frames wait while an answer is due, so answers keep order
			for (int i = NSTAT - 1; i >= 0; i--) begin
				if (q.stat_pend[i]) begin
					next_q.r_fid = STAT_CODE[i];
					stat_clr = '0;
					stat_clr[i] = 1'b1;
				end
			end
			next_q.r_type = TYPE_STAT;
			next_q.tx_busy = 1'b1;
			next_q.tx_idx = '0;
			next_q.tx_sum = '0;
			next_q.tx_last = IDX_TYPE + 4'(STAT_LEN);
		end
		// A new event in the clearing cycle stays pending
		next_q.stat_pend = (q.stat_pend & ~stat_clr) | {status_event, 1'b0};
		// Frame builder; the FIFO's ready stalls it
		tx_byte = '0;
		unique case (q.tx_idx)
			4'h0: tx_byte = DELIM;
			// Frames stay short, so the high length byte is always zero
			IDX_LENH: tx_byte = 8'h00;
			IDX_LEN: tx_byte = (q.r_type == TYPE_STAT) ? STAT_LEN : RESP_LEN_BASE + {6'h00, q.r_dlen};
			IDX_TYPE: tx_byte = q.r_type;
			IDX_FID: tx_byte = q.r_fid;
			IDX_CMDH: tx_byte = q.r_cmd[15:8];
			IDX_CMDL: tx_byte = q.r_cmd[7:0];
			IDX_ST: tx_byte = q.r_st;
			IDX_D0: tx_byte = (q.r_dlen == 2'd2) ? q.r_data[15:8] : q.r_data[7:0];
			default: tx_byte = q.r_data[7:0];
		endcase
		if (q.tx_idx == q.tx_last) begin
			tx_byte = CSUM_TARGET - q.tx_sum;
		end
		push = q.tx_busy;
		if (push && push_ok) begin
			next_q.tx_idx = q.tx_idx + 1'b1;
			if (q.tx_idx >= IDX_TYPE) begin
				next_q.tx_sum = q.tx_sum + tx_byte;
			end
			if (q.tx_idx == q.tx_last) begin
				next_q.tx_busy = 1'b0;
			end
		end
		next_q.rx_rdy = (next_q.rs != R_EXEC);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.rs <= R_DELIM;
			q.act <= SLOT_RST;
			q.stat_pend <= NSTAT'(1);
			q.rx_rdy <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////
	lcfh_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_data(tx_byte),
		.in_ready(push_ok),
		.out_valid(tx_valid),
		.out_data(tx_data),
		.out_ready(tx_ready)
	);

	assign rx_ready = q.rx_rdy;
	assign serial_baud_setting = q.act[0];
	assign api_escape_mode_setting = q.act[1];
	assign pending_flags = q.pv;

	////////////////////////////////////////////////////////////////
	// Checks
	// Marks the first identifier byte pushed, and keeps the identifier of the request being answered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_type <= 1'b0;
			req_fid <= '0;
		end else begin
			if (push && push_ok && q.tx_idx == IDX_FID) begin
				seen_type <= 1'b1;
			end
			if (exec_go) begin
				req_fid <= q.fid;
			end
		end
	end

	property p_bad_csum;
		@(posedge clk) disable iff (!rst_n)
		(q.rs == R_CSUM && acc && !csum_good && !q.tx_busy && q.stat_pend == '0)
		|=> (q.rs == R_DELIM) && !q.tx_busy;
	endproperty
	a_bad_csum: assert property (p_bad_csum) else $error("bad checksum frame not dropped");

	property p_short;
		@(posedge clk) disable iff (!rst_n)
		(q.rs == R_CSUM && acc && q.len < MIN_LEN) |=> (q.rs == R_DELIM) ##1 $stable(q.act);
	endproperty
	a_short: assert property (p_short) else $error("short frame not dropped");

	property p_imm_type;
		@(posedge clk) disable iff (!rst_n)
		(q.rs == R_CSUM && acc && csum_good && q.len >= MIN_LEN && q.ftype == TYPE_IMM)
		|=> (q.rs == R_EXEC) && !rx_ready;
	endproperty
	a_imm_type: assert property (p_imm_type) else $error("immediate frame not executed");

	property p_fid_zero;
		@(posedge clk) disable iff (!rst_n)
		(exec_go && q.fid == '0 && q.stat_pend == '0) |=> !q.tx_busy;
	endproperty
	a_fid_zero: assert property (p_fid_zero) else $error("answer sent for zero identifier");

	property p_imm_set;
		@(posedge clk) disable iff (!rst_n)
		(exec_go && q.ftype == TYPE_IMM && q.has_val && q.cmd == SLOT_CMD[0])
		|=> serial_baud_setting == $past(q.val);
	endproperty
	a_imm_set: assert property (p_imm_set) else $error("immediate set not applied");

	property p_que_set;
		@(posedge clk) disable iff (!rst_n)
		(exec_go && q.ftype == TYPE_QUE && q.has_val && q.cmd == SLOT_CMD[0])
		|=> $stable(serial_baud_setting) && pending_flags[0];
	endproperty
	a_que_set: assert property (p_que_set) else $error("queued set applied early");

	property p_echo;
		@(posedge clk) disable iff (!rst_n)
		(push && q.tx_idx == IDX_FID && q.r_type == TYPE_RESP) |-> tx_byte == req_fid;
	endproperty
	a_echo: assert property (p_echo) else $error("identifier not echoed");

	property p_out_csum;
		@(posedge clk) disable iff (!rst_n)
		(push && q.tx_idx == q.tx_last) |-> 8'(tx_byte + q.tx_sum) == CSUM_TARGET;
	endproperty
	a_out_csum: assert property (p_out_csum) else $error("sent checksum wrong");

	property p_boot;
		@(posedge clk) disable iff (!rst_n)
		(push && !seen_type && q.tx_idx == IDX_FID) |-> tx_byte == STAT_CODE[0];
	endproperty
	a_boot: assert property (p_boot) else $error("first frame is not the boot status");

	property p_len_high;
		@(posedge clk) disable iff (!rst_n)
		(push && q.tx_idx == IDX_LENH) |-> tx_byte == 8'h00;
	endproperty
	a_len_high: assert property (p_len_high) else $error("length high byte not zero");

	property p_len_low;
		@(posedge clk) disable iff (!rst_n)
		(push && q.tx_idx == IDX_LEN) |-> tx_byte == {4'h0, q.tx_last - IDX_TYPE};
	endproperty
	a_len_low: assert property (p_len_low) else $error("length byte does not match frame");

	property p_apply;
		@(posedge clk) disable iff (!rst_n)
		(exec_go && q.cmd == CMD_APPLY) |=> pending_flags == '0;
	endproperty
	a_apply: assert property (p_apply) else $error("apply left values pending");

	// While a baud value is pending, nothing but an executed frame may move serial_baud_setting
	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		(pending_flags[0] && !exec_go) |=> $stable(serial_baud_setting);
	endproperty
	a_hold: assert property (p_hold) else $error("pending value changed active setting");

	c_resp: cover property (@(posedge clk) disable iff (!rst_n) push && q.r_type == TYPE_RESP && q.tx_idx == IDX_ST);
	c_stat: cover property (@(posedge clk) disable iff (!rst_n) push && q.r_type == TYPE_STAT && q.tx_idx == IDX_FID);
	c_queue: cover property (@(posedge clk) disable iff (!rst_n) exec_go && q.ftype == TYPE_QUE && q.has_val);
	c_badsum: cover property (@(posedge clk) disable iff (!rst_n) q.rs == R_CSUM && acc && !csum_good);
	c_apply: cover property (@(posedge clk) disable iff (!rst_n) exec_go && q.cmd == CMD_APPLY);
endmodule
`default_nettype wire

// File: lcfh_host.sv
// Host model: sends request frames on the receive stream and collects every transmit byte.
// Assumes send_frame is called from a process that has just woken on a rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module lcfh_host (
	input wire logic clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	input wire logic stall
);
	import lcfh_pkg::*;
	logic [7:0] got[$];
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	always @(posedge clk) begin
		tx_ready <= ~stall;
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			got.push_back(tx_data);
		end
	end
	////////////////////////////////////////
	// Byte stays up until rx_ready is seen high at an edge
	task automatic put(input logic [7:0] b);
		rx_valid <= 1'b1;
		rx_data <= b;
		do @(posedge clk); while (rx_ready !== 1'b1);
	endtask
	task automatic send_frame(input logic [7:0] ftype, input logic [7:0] fid, input logic [15:0] cmd,
			input logic has_val, input logic [7:0] val, input logic [7:0] flip, input logic short_len);
		logic [7:0] body[$];
		logic [7:0] sum;
		body = {ftype, fid, cmd[15:8], cmd[7:0]};
		if (has_val) body.push_back(val);
		if (short_len) body = body[0:1];
		sum = 8'h00;
		foreach (body[i]) sum += body[i];
		put(DELIM);
		put(8'h00);
		put(8'(body.size()));
		foreach (body[i]) put(body[i]);
		put((8'hff - sum) ^ flip);
		rx_valid <= 1'b0;
		// Idle data inverted so a stale byte cannot pass for a fresh one
		rx_data <= ~rx_data;
	endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the local command frame handler.
// Assumes the host model lcfh_host and the package lcfh_pkg are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import lcfh_pkg::*;
	typedef logic [7:0] lcfh_bq_t[$];
	logic clk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready, stall;
	logic [7:0] rx_data, tx_data, serial_baud_setting, api_escape_mode_setting;
	logic [15:0] temp_value;
	logic [NSTAT-1:1] status_event;
	logic [NSLOT-1:0] pending_flags;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	lcfh_top dut_u (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .temp_value(temp_value),
		.status_event(status_event), .serial_baud_setting(serial_baud_setting),
		.api_escape_mode_setting(api_escape_mode_setting), .pending_flags(pending_flags));
	lcfh_host host_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .stall(stall));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	////////////////////////////////////////
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Expected frame is wrapped in delimiter, length and checksum here, not by the design
	task automatic expect_frame(input lcfh_bq_t body);
		lcfh_bq_t f;
		logic [7:0] sum;
		int n;
		sum = 8'h00;
		n = 0;
		foreach (body[i]) sum += body[i];
		f = {DELIM, 8'h00, 8'(body.size())};
		f = {f, body};
		f.push_back(8'hff - sum);
		while (host_u.got.size() < f.size() && n < 400) begin
			@(posedge clk);
			n++;
		end
		check("frame complete", {15'h0000, host_u.got.size() >= f.size()}, 16'h0001);
		foreach (f[i]) begin
			if (host_u.got.size() > 0) check("tx byte", host_u.got.pop_front(), f[i]);
		end
	endtask
	task automatic quiet(input string name);
		repeat (60) @(posedge clk);
		check(name, 16'(host_u.got.size()), 16'h0000);
	endtask
	////////////////////////////////////////
	task automatic t_boot();
		expect_frame('{TYPE_STAT, 8'h00});
		check("baud reset", serial_baud_setting, 16'h0003);
		check("api reset", api_escape_mode_setting, 16'h0001);
		check("pending reset", pending_flags, 16'h0000);
		check("rx ready idle", rx_ready, 16'h0001);
	endtask
	task automatic t_query();
		host_u.send_frame(TYPE_IMM, 8'h17, 16'h4244, 1'b0, 8'h00, 8'h00, 1'b0);
		expect_frame('{8'h88, 8'h17, 8'h42, 8'h44, 8'h00, 8'h03});
		host_u.send_frame(TYPE_QUE, 8'h22, 16'h4150, 1'b0, 8'h00, 8'h00, 1'b0);
		expect_frame('{8'h88, 8'h22, 8'h41, 8'h50, 8'h00, 8'h01});
	endtask
	task automatic t_queue();
		host_u.send_frame(TYPE_QUE, 8'h53, 16'h4244, 1'b1, 8'h07, 8'h00, 1'b0);
		expect_frame('{8'h88, 8'h53, 8'h42, 8'h44, 8'h00});
		check("baud while queued", serial_baud_setting, 16'h0003);
		check("pending after queue", pending_flags, 16'h0001);
		host_u.send_frame(TYPE_QUE, 8'h54, 16'h4244, 1'b0, 8'h00, 8'h00, 1'b0);
		expect_frame('{8'h88, 8'h54, 8'h42, 8'h44, 8'h00, 8'h03});
		host_u.send_frame(TYPE_QUE, 8'h05, 16'h4143, 1'b0, 8'h00, 8'h00, 1'b0);
		expect_frame('{8'h88, 8'h05, 8'h41, 8'h43, 8'h00});
		check("baud applied", serial_baud_setting, 16'h0007);
		check("pending applied", pending_flags, 16'h0000);
	endtask
	task automatic t_imm();
		host_u.send_frame(TYPE_QUE, 8'h00, 16'h4150, 1'b1, 8'h05, 8'h00, 1'b0);
		quiet("answer to id zero");
		check("api pending", pending_flags, 16'h0002);
		temp_value <= 16'h1234;
		host_u.send_frame(TYPE_IMM, 8'h09, 16'h5450, 1'b0, 8'h00, 8'h00, 1'b0);
		expect_frame('{8'h88, 8'h09, 8'h54, 8'h50, 8'h00, 8'h12, 8'h34});
		check("api after immediate", api_escape_mode_setting, 16'h0005);
		host_u.send_frame(TYPE_IMM, 8'h00, 16'h4244, 1'b1, 8'h0a, 8'h00, 1'b0);
		quiet("answer to id zero");
		check("baud immediate", serial_baud_setting, 16'h000a);
	endtask
	task automatic t_bad();
		host_u.send_frame(TYPE_IMM, 8'h01, 16'h4244, 1'b1, 8'h55, 8'h01, 1'b0);
		quiet("answer to bad checksum");
		check("baud after bad checksum", serial_baud_setting, 16'h000a);
		host_u.send_frame(TYPE_IMM, 8'h02, 16'h4244, 1'b0, 8'h00, 8'h00, 1'b1);
		quiet("answer to short frame");
		host_u.send_frame(TYPE_IMM, 8'h03, 16'h4244, 1'b0, 8'h00, 8'h00, 1'b0);
		expect_frame('{8'h88, 8'h03, 8'h42, 8'h44, 8'h00, 8'h0a});
	endtask
	// Stalled sink: answer plus five status frames overflow the buffer and the builder waits
	task automatic t_stall();
		logic [7:0] codes[5];
		codes = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h0d};
		stall <= 1'b1;
		temp_value <= 16'hfffe;
		host_u.send_frame(TYPE_IMM, 8'h33, 16'h5450, 1'b0, 8'h00, 8'h00, 1'b0);
		repeat (20) @(posedge clk);
		status_event <= 5'h1f;
		@(posedge clk);
		status_event <= 5'h00;
		repeat (100) @(posedge clk);
		check("held tx valid", tx_valid, 16'h0001);
		check("held tx data", tx_data, 16'h007e);
		stall <= 1'b0;
		expect_frame('{8'h88, 8'h33, 8'h54, 8'h50, 8'h00, 8'hff, 8'hfe});
		foreach (codes[i]) expect_frame('{TYPE_STAT, codes[i]});
	endtask
	////////////////////////////////////////
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		rst_n = 1'b0;
		stall = 1'b0;
		status_event = 5'h00;
		temp_value = 16'hfffe;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_boot();
		t_query();
		t_queue();
		t_imm();
		t_bad();
		t_stall();
		final_report();
	end
endmodule
`default_nettype wire
